// File: rtl/tcc_timer.sv
// The address map and the AHB-Lite register port were left to the implementer.
`default_nettype none

module tcc_timer (
    // Clock and reset
    input  wire logic                            hclk,
    input  wire logic                            hresetn,
    // Register bus
    input  wire tcc_pkg::tcc_ahb_req_type        ahb_req,
    output tcc_pkg::tcc_ahb_rsp_type             ahb_rsp,
    // Edge input pins
    input  wire logic                            edge_input_a,
    input  wire logic                            edge_input_b,
    // Timer output pin
    output logic                                 timer_output_pin,
    // Event pulses
    output logic                                 irq_a,
    output logic                                 irq_b
);
    import tcc_pkg::*;

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [1:0]           mode;
        logic                 toggle_sel;
        logic                 ovf;
        logic                 cap_a;
        logic                 revph;
        logic                 cap_b;
        logic                 out_en;
        logic [1:0]           pre_sel;
        logic [1:0]           edge_a;
        logic [1:0]           edge_b;
        logic [TCC_CNT_W-1:0] cnt;
        logic [TCC_CNT_W-1:0] reg_a;
        logic [TCC_CNT_W-1:0] reg_b;
        logic                 out_lvl;
        logic                 pin;
        logic                 irq_a;
        logic                 irq_b;
        logic                 dp_wr;
        logic [TCC_OFS_W-1:0] dp_addr;
        logic [31:0]          hrdata;
    } tcc_state_type;

    tcc_state_type q;
    tcc_state_type d;

    logic running;
    logic tick;

    // Filtered pin edges.
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;

    // Qualified events.
    logic a_valid;
    logic a_rev;
    logic b_valid;
    logic edge_clear;
    logic match_a;
    logic match_b;
    logic toggle;

    // Bus decode.
    logic accept;
    logic mapped;

    // ==========================================================
    // Edge qualification helpers
    // ==========================================================
    // True on a valid edge of one pin.
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic       r,
                                      input logic       f);
        logic hit;

        hit = 1'b0;
        unique case (sel)
            TCC_EDGE_FALL: hit = f;
            TCC_EDGE_RISE: hit = r;
            TCC_EDGE_BOTH: hit = r | f;
            TCC_EDGE_NONE: hit = 1'b0;
        endcase
        return hit;
    endfunction : edge_hit

    // With both edges valid there is no opposite phase left.
    function automatic logic edge_rev(input logic [1:0] sel,
                                      input logic       r,
                                      input logic       f);
        logic hit;

        hit = 1'b0;
        unique case (sel)
            TCC_EDGE_FALL: hit = r;
            TCC_EDGE_RISE: hit = f;
            TCC_EDGE_BOTH: hit = 1'b0;
            TCC_EDGE_NONE: hit = 1'b0;
        endcase
        return hit;
    endfunction : edge_rev

    // ==========================================================
    // Sub-blocks
    // ==========================================================
    // Stopped modes hold the divider cleared.
    tcc_prescaler u_pre (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (running),
        .sel     (q.pre_sel),
        .tick    (tick)
    );

    // Both pins are sampled on the count clock.
    tcc_edge_filter u_filt_a (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (edge_input_a),
        .sample  (tick),
        .rise    (a_rise),
        .fall    (a_fall)
    );

    tcc_edge_filter u_filt_b (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (edge_input_b),
        .sample  (tick),
        .rise    (b_rise),
        .fall    (b_fall)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        d       = q;
        d.irq_a = 1'b0;
        d.irq_b = 1'b0;

        running = (q.mode == TCC_MODE_FREE) || (q.mode == TCC_MODE_CLEAR);
        a_valid = running && edge_hit(q.edge_a, a_rise, a_fall);
        a_rev   = running && edge_rev(q.edge_a, a_rise, a_fall);
        b_valid = running && edge_hit(q.edge_b, b_rise, b_fall);


        edge_clear = (q.mode == TCC_MODE_CLEAR) && a_valid;
        match_a    = running && tick && !q.cap_a && (q.cnt == q.reg_a);
        match_b    = running && tick && !q.cap_b && (q.cnt == q.reg_b);

        // Register writes land in the data phase; hardware events
        // below are applied afterwards so that they win.
        if (q.dp_wr) begin
            unique case (q.dp_addr)
                TCC_OFS_MODE: begin
                    d.mode       = ahb_req.hwdata[TCC_MODE_FIELD_LO +: 2];
                    d.toggle_sel = ahb_req.hwdata[TCC_MODE_TOGGLE_BIT];
                    if (!ahb_req.hwdata[TCC_MODE_OVF_BIT]) begin
                        d.ovf = 1'b0;
                    end
                end
                TCC_OFS_CAPCTL: begin
                    d.cap_a = ahb_req.hwdata[TCC_CAP_A_BIT];
                    d.revph = ahb_req.hwdata[TCC_REVPH_BIT];
                    d.cap_b = ahb_req.hwdata[TCC_CAP_B_BIT];
                end
                TCC_OFS_OUTCTL: begin
                    d.out_en = ahb_req.hwdata[TCC_OUT_EN_BIT];
                end
                TCC_OFS_PRESC: begin
                    d.pre_sel = ahb_req.hwdata[TCC_PRE_SEL_LO +: 2];
                    d.edge_a  = ahb_req.hwdata[TCC_EDGE_A_LO +: 2];
                    d.edge_b  = ahb_req.hwdata[TCC_EDGE_B_LO +: 2];
                end
                TCC_OFS_REG_A: begin
                    d.reg_a = ahb_req.hwdata[TCC_CNT_W-1:0];
                end
                TCC_OFS_REG_B: begin
                    d.reg_b = ahb_req.hwdata[TCC_CNT_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Counter: an input-A clear beats a count tick on the same cycle.
        if (!running) begin
            d.cnt = TCC_COUNT_ZERO;
        end else if (edge_clear) begin
            d.cnt = TCC_COUNT_ZERO;
        end else if (tick) begin
            d.cnt = q.cnt + TCC_COUNT_ONE;
        end


        // A clear on the wrap cycle hides the overflow.
        if (running && tick && !edge_clear && q.cnt == TCC_COUNT_MAX) begin
            d.ovf = 1'b1;
        end


        // Register A as capture register.
        if (running && q.cap_a) begin
            if (q.revph) begin
                if (a_rev) begin
                    d.reg_a = q.cnt;
                end
                if (b_valid) begin
                    d.irq_a = 1'b1;
                end
            end else if (b_valid) begin
                d.reg_a = q.cnt;
                d.irq_a = 1'b1;
            end
        end


        // Register B as capture register, input A only.
        if (q.cap_b && a_valid) begin
            d.reg_b = q.cnt;
            d.irq_b = 1'b1;
        end


        // Matches never clear the counter.
        if (match_a) begin
            d.irq_a = 1'b1;
        end
        if (match_b) begin
            d.irq_b = 1'b1;
        end


        // Matches always invert; input-A edges only with edge toggling on.
        toggle = match_a || match_b || (q.toggle_sel && a_valid);
        if (!running) begin
            d.out_lvl = 1'b0;
        end else if (toggle) begin
            d.out_lvl = !q.out_lvl;
        end

        // The enable gates the pin, not the phase.
        d.pin = q.out_en && d.out_lvl;


        // Address phase: capture decode and the read value.
        accept    = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
        mapped    = (ahb_req.haddr[31:TCC_OFS_W] == '0);
        d.dp_wr   = accept && ahb_req.hwrite && mapped;
        d.dp_addr = ahb_req.haddr[TCC_OFS_W-1:0];
        d.hrdata  = 32'h0000_0000;

        if (accept && !ahb_req.hwrite && mapped) begin
            // Read from the next state so a write just before is seen.
            unique case (ahb_req.haddr[TCC_OFS_W-1:0])
                TCC_OFS_MODE: begin
                    d.hrdata[TCC_MODE_FIELD_LO +: 2]  = d.mode;
                    d.hrdata[TCC_MODE_TOGGLE_BIT]     = d.toggle_sel;
                    d.hrdata[TCC_MODE_OVF_BIT]        = d.ovf;
                end
                TCC_OFS_CAPCTL: begin
                    d.hrdata[TCC_CAP_A_BIT] = d.cap_a;
                    d.hrdata[TCC_REVPH_BIT] = d.revph;
                    d.hrdata[TCC_CAP_B_BIT] = d.cap_b;
                end
                TCC_OFS_OUTCTL: begin
                    d.hrdata[TCC_OUT_EN_BIT] = d.out_en;
                end
                TCC_OFS_PRESC: begin
                    d.hrdata[TCC_PRE_SEL_LO +: 2] = d.pre_sel;
                    d.hrdata[TCC_EDGE_A_LO +: 2]  = d.edge_a;
                    d.hrdata[TCC_EDGE_B_LO +: 2]  = d.edge_b;
                end
                TCC_OFS_COUNT: begin
                    d.hrdata[TCC_CNT_W-1:0] = d.cnt;
                end
                TCC_OFS_REG_A: begin
                    d.hrdata[TCC_CNT_W-1:0] = d.reg_a;
                end
                TCC_OFS_REG_B: begin
                    d.hrdata[TCC_CNT_W-1:0] = d.reg_b;
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // The slave never stalls, so every transfer is zero wait.
    assign ahb_rsp.hrdata    = q.hrdata;
    assign ahb_rsp.hreadyout = 1'b1;
    assign ahb_rsp.hresp     = TCC_HRESP_OKAY;

    // Pins and event pulses.
    assign timer_output_pin  = q.pin;
    assign irq_a             = q.irq_a;
    assign irq_b             = q.irq_b;

endmodule : tcc_timer

`default_nettype wire

// File: rtl/tcc_pkg.sv
`default_nettype none

package tcc_pkg;

    // ==========================================================
    // Widths and counter limits
    // ==========================================================
    localparam int          TCC_CNT_W      = 16;
    localparam int          TCC_OFS_W      = 8;
    localparam int          TCC_PRE_W      = 3;
    localparam logic [15:0] TCC_COUNT_ZERO = 16'h0000;
    localparam logic [15:0] TCC_COUNT_MAX  = 16'hFFFF;
    localparam logic [15:0] TCC_COUNT_ONE  = 16'h0001;

    // ==========================================================
    // Register byte offsets
    // ==========================================================
    localparam logic [7:0] TCC_OFS_MODE   = 8'h00;
    localparam logic [7:0] TCC_OFS_CAPCTL = 8'h04;
    localparam logic [7:0] TCC_OFS_OUTCTL = 8'h08;
    localparam logic [7:0] TCC_OFS_PRESC  = 8'h0C;
    localparam logic [7:0] TCC_OFS_COUNT  = 8'h10;
    localparam logic [7:0] TCC_OFS_REG_A  = 8'h14;
    localparam logic [7:0] TCC_OFS_REG_B  = 8'h18;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int TCC_MODE_OVF_BIT    = 0;
    localparam int TCC_MODE_TOGGLE_BIT = 1;
    localparam int TCC_MODE_FIELD_LO   = 2;
    localparam int TCC_CAP_A_BIT       = 0;
    localparam int TCC_REVPH_BIT       = 1;
    localparam int TCC_CAP_B_BIT       = 2;
    localparam int TCC_OUT_EN_BIT      = 0;
    localparam int TCC_PRE_SEL_LO      = 0;
    localparam int TCC_EDGE_A_LO       = 3;
    localparam int TCC_EDGE_B_LO       = 5;

    // ==========================================================
    // Encodings
    // ==========================================================
    localparam logic [1:0] TCC_MODE_STOP  = 2'h0;
    localparam logic [1:0] TCC_MODE_FREE  = 2'h1;
    localparam logic [1:0] TCC_MODE_CLEAR = 2'h2;
    localparam logic [1:0] TCC_EDGE_FALL  = 2'h0;
    localparam logic [1:0] TCC_EDGE_RISE  = 2'h1;
    localparam logic [1:0] TCC_EDGE_NONE  = 2'h2;
    localparam logic [1:0] TCC_EDGE_BOTH  = 2'h3;
    localparam logic       TCC_HRESP_OKAY = 1'b0;

    // ==========================================================
    // Bus carriers
    // ==========================================================
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } tcc_ahb_req_type;

    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } tcc_ahb_rsp_type;

endpackage : tcc_pkg

`default_nettype wire

// File: rtl/tcc_prescaler.sv
`default_nettype none

module tcc_prescaler (
    // Clock and reset
    input  wire logic                            hclk,
    input  wire logic                            hresetn,
    // Control
    input  wire logic                            run,
    input  wire logic [1:0]                      sel,
    // Count clock enable
    output logic                                 tick
);
    import tcc_pkg::*;

    typedef struct packed {
        logic [TCC_PRE_W-1:0] cnt;
        logic                 tick;
    } tcc_pre_state_type;

    tcc_pre_state_type q;
    tcc_pre_state_type d;
    logic [TCC_PRE_W-1:0] mask;

    // ==========================================================
    // Divider: one tick every 2**sel clocks
    // ==========================================================
    always_comb begin
        d    = q;
        mask = TCC_PRE_W'((1 << sel) - 1);
        if (!run) begin
            d.cnt  = '0;
            d.tick = 1'b0;
        end else begin
            d.tick = ((q.cnt & mask) == mask);
            d.cnt  = q.cnt + TCC_PRE_W'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;

endmodule : tcc_prescaler

`default_nettype wire

// File: rtl/tcc_edge_filter.sv
`default_nettype none

module tcc_edge_filter (
    // Clock and reset
    input  wire logic                            hclk,
    input  wire logic                            hresetn,
    // Pin and sample strobe
    input  wire logic                            pin,
    input  wire logic                            sample,
    // Accepted edges
    output logic                                 rise,
    output logic                                 fall
);
    import tcc_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic smp;
        logic lvl;
        logic rise;
        logic fall;
    } tcc_filt_state_type;

    tcc_filt_state_type q;
    tcc_filt_state_type d;

    // ==========================================================
    // Two-sample glitch filter
    // ==========================================================
    // A new level is accepted only when two consecutive samples
    // agree, so a pulse shorter than one sample period is dropped.
    always_comb begin
        d      = q;
        d.s1   = pin;
        d.s2   = q.s1;
        d.rise = 1'b0;
        d.fall = 1'b0;
        if (sample) begin
            d.smp = q.s2;
            if (q.s2 == q.smp && q.s2 != q.lvl) begin
                d.lvl  = q.s2;
                d.rise = q.s2;
                d.fall = !q.s2;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rise = q.rise;
    assign fall = q.fall;

endmodule : tcc_edge_filter

`default_nettype wire

// File: test/tcc_timer_sva.sv
`default_nettype none

module tcc_timer_sva
    import tcc_pkg::*;
(
    // Clock and reset
    input wire logic                     hclk,
    input wire logic                     hresetn,
    // Register bus
    input wire tcc_pkg::tcc_ahb_req_type ahb_req,
    input wire tcc_pkg::tcc_ahb_rsp_type ahb_rsp,
    // Pins and events
    input wire logic                     edge_input_a,
    input wire logic                     edge_input_b,
    input wire logic                     timer_output_pin,
    input wire logic                     irq_a,
    input wire logic                     irq_b
);
    // ====================
    // Shadow of the setup
    // ====================
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] ofs;
        logic [3:0] mode;
        logic [2:0] cap;
        logic       oen;
        logic [3:0] age;
        logic       a;
        logic       b;
        logic [4:0] a_age;
        logic [4:0] b_age;
    } tcc_chk_type;

    tcc_chk_type h_q;
    logic        go;
    logic        quiet;
    logic        free;

    assign go    = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1]
                   && (ahb_req.haddr[31:8] == 24'h000000);
    // Settings need a few cycles to reach the pins, so checks wait until they have settled.
    assign quiet = (h_q.age > 4'h3);
    assign free  = (h_q.mode[3:2] == TCC_MODE_FREE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            h_q <= '0;
        end else begin
            h_q.wr    <= go && ahb_req.hwrite;
            h_q.rd    <= go && !ahb_req.hwrite;
            h_q.ofs   <= ahb_req.haddr[7:0];
            h_q.a     <= edge_input_a;
            h_q.b     <= edge_input_b;
            h_q.age   <= (h_q.wr && h_q.ofs < TCC_OFS_COUNT) ? 4'h0
                         : h_q.age + {3'h0, ~&h_q.age};
            h_q.a_age <= (edge_input_a != h_q.a) ? 5'h00 : h_q.a_age + {4'h0, ~&h_q.a_age};
            h_q.b_age <= (edge_input_b != h_q.b) ? 5'h00 : h_q.b_age + {4'h0, ~&h_q.b_age};
            if (h_q.wr && h_q.ofs == TCC_OFS_MODE) h_q.mode <= ahb_req.hwdata[3:0];
            if (h_q.wr && h_q.ofs == TCC_OFS_CAPCTL) h_q.cap <= ahb_req.hwdata[2:0];
            if (h_q.wr && h_q.ofs == TCC_OFS_OUTCTL) h_q.oen <= ahb_req.hwdata[0];
        end
    end

    // ====================
    // Properties
    // ====================
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence cmp_evt_s;
        irq_a || irq_b;
    endsequence

    sequence b_recent_s;
        h_q.b_age < 5'h10;
    endsequence

    hready_okay_a: assert property (ahb_rsp.hreadyout && ahb_rsp.hresp == TCC_HRESP_OKAY)
        else $error("bus slave not ready or not OKAY");
    rdata_idle_a: assert property (!h_q.rd |-> ahb_rsp.hrdata == 32'h00000000)
        else $error("read data outside a read data phase");
    irqa_pulse_a: assert property (irq_a |=> !irq_a)
        else $error("irq_a longer than one cycle");
    irqb_pulse_a: assert property (irq_b |=> !irq_b)
        else $error("irq_b longer than one cycle");
    stop_quiet_a: assert property (quiet && !free && h_q.mode[3:2] != TCC_MODE_CLEAR
        |-> !irq_a && !irq_b && !timer_output_pin)
        else $error("activity while the timer is stopped");
    cmp_toggle_a: assert property (quiet && free && h_q.cap == 3'h0 && h_q.oen
        && !h_q.mode[1] && $changed(timer_output_pin) |-> cmp_evt_s)
        else $error("output toggled without a compare match");
    cap_still_a: assert property (quiet && free && h_q.cap[0] && h_q.cap[2]
        && !h_q.mode[1] |-> $stable(timer_output_pin))
        else $error("output moved with both registers capturing");
    revph_irq_a: assert property (quiet && h_q.cap[0] && h_q.cap[1] && irq_a
        |-> b_recent_s)
        else $error("irq_a without an input b edge under reverse phase");
    capb_src_a: assert property (quiet && free && h_q.cap[2] && irq_b
        |-> h_q.a_age < 5'h10)
        else $error("irq_b without an input a edge in capture mode");
endmodule : tcc_timer_sva

bind tcc_timer tcc_timer_sva chk (
    .hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
    .edge_input_a(edge_input_a), .edge_input_b(edge_input_b),
    .timer_output_pin(timer_output_pin), .irq_a(irq_a), .irq_b(irq_b)
);

`default_nettype wire

// File: test/tcc_edge_src.sv
`default_nettype none

module tcc_edge_src (
    // Clock
    input  wire logic hclk,
    // Edge pins
    output var logic  edge_a,
    output var logic  edge_b
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        edge_a = 1'b0;
        edge_b = 1'b0;
    end

    // A level always stands whole cycles; a hold of one cycle is the shortest glitch.
    task automatic drive(input logic sel_b, input logic v, input int hold);
        if (sel_b) edge_b <= v;
        else edge_a <= v;
        repeat (hold) @(posedge hclk);
    endtask : drive
endmodule : tcc_edge_src

`default_nettype wire

// File: test/tcc_timer_tb.sv
`default_nettype none

module tcc_timer_tb
    import tcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic            hclk;
    logic            hresetn;
    tcc_ahb_req_type m;
    tcc_ahb_req_type bus_req;
    tcc_ahb_rsp_type rsp;
    wire logic       pin_a;
    wire logic       pin_b;
    logic            pin_o;
    logic            irq_a;
    logic            irq_b;
    int              err_count, total_checks, ca, cb, ba, bb, cyc;
    logic [31:0]     q, v;
    logic [7:0]      regs [7] = '{TCC_OFS_MODE, TCC_OFS_CAPCTL, TCC_OFS_OUTCTL,
                                  TCC_OFS_PRESC, TCC_OFS_COUNT, TCC_OFS_REG_A, TCC_OFS_REG_B};

    always_comb begin
        bus_req        = m;
        bus_req.hready = rsp.hreadyout;
    end

    tcc_timer dut (
        .hclk             (hclk),
        .hresetn          (hresetn),
        .ahb_req          (bus_req),
        .ahb_rsp          (rsp),
        .edge_input_a     (pin_a),
        .edge_input_b     (pin_b),
        .timer_output_pin (pin_o),
        .irq_a            (irq_a),
        .irq_b            (irq_b)
    );

    tcc_edge_src src (.hclk(hclk), .edge_a(pin_a), .edge_b(pin_b));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ====================
    // Event counting and timeout
    // ====================
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (irq_a === 1'b1) ca <= ca + 1;
        if (irq_b === 1'b1) cb <= cb + 1;
        if (cyc == 90000) begin
            err_count = err_count + 1;
            complete_run();
        end
    end

    // ====================
    // Tasks
    // ====================
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wait_rdy();
        @(posedge hclk);
        while (rsp.hreadyout !== 1'b1) begin
            @(posedge hclk);
        end
    endtask : wait_rdy

    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        m.hsel   <= 1'b1;
        m.haddr  <= a;
        m.htrans <= 2'h2;
        m.hwrite <= wr;
        wait_rdy();
        m.hsel   <= 1'b0;
        m.htrans <= 2'h0;
        m.hwdata <= wr ? d : 32'h00000000;
        wait_rdy();
        q = rsp.hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, {24'h000000, a}, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        xfer(1'b0, {24'h000000, a}, 32'h00000000);
    endtask : rd

    // Counts events since the previous call, so each scenario sees only its own pulses.
    task automatic evts(input int ea, input int eb);
        check("irq_a count", 32'(ca - ba), 32'(ea));
        check("irq_b count", 32'(cb - bb), 32'(eb));
        ba = ca;
        bb = cb;
    endtask : evts

    // Stopping first zeroes the count, so every scenario starts from a known count.
    task automatic setup(input logic [31:0] cap, input logic [31:0] pre, input logic [31:0] md);
        wr(TCC_OFS_MODE, 32'h00000000);
        wr(TCC_OFS_CAPCTL, cap);
        wr(TCC_OFS_PRESC, pre);
        wr(TCC_OFS_OUTCTL, 32'h00000001);
        wr(TCC_OFS_MODE, md);
        ba = ca;
        bb = cb;
    endtask : setup

    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    // ====================
    // Main sequence
    // ====================
    initial begin
        err_count = 0;
        total_checks = 0;
        {ca, cb, ba, bb, cyc} = '0;
        m = '0;
        m.hsize = 3'h2;
        hresetn = 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (regs[i]) begin
            rd(regs[i]);
            check("reset value", q, 32'h00000000);
        end
        xfer(1'b1, 32'h00000100, 32'h0000000F);
        xfer(1'b0, 32'h00000100, 32'h00000000);
        check("unmapped read", q, 32'h00000000);
        rd(TCC_OFS_MODE);
        check("unmapped write ignored", q, 32'h00000000);
        wr(TCC_OFS_REG_A, 32'h00000005);
        wr(TCC_OFS_REG_B, 32'h00000040);
        setup(32'h0, 32'h0, 32'h4);
        repeat (30) @(posedge hclk);
        evts(1, 0);
        check("pin after match a", {31'h0, pin_o}, 32'h1);
        repeat (60) @(posedge hclk);
        evts(0, 1);
        check("pin after match b", {31'h0, pin_o}, 32'h0);
        rd(TCC_OFS_COUNT);
        v = q;
        rd(TCC_OFS_COUNT);
        check("count step", q - v, 32'h00000002);
        repeat (65536) @(posedge hclk);
        evts(1, 1);
        rd(TCC_OFS_MODE);
        check("overflow flag", q, 32'h00000005);
        wr(TCC_OFS_MODE, 32'h00000004);
        rd(TCC_OFS_MODE);
        check("overflow cleared", q, 32'h00000004);
        wr(TCC_OFS_REG_B, 32'h00000300);
        setup(32'h3, 32'h28, 32'hA);
        repeat (40) @(posedge hclk);
        src.drive(1'b0, 1'b1, 12);
        rd(TCC_OFS_COUNT);
        check("cleared count", {31'h0, q < 32'h14}, 32'h1);
        check("pin on clear", {31'h0, pin_o}, 32'h1);
        src.drive(1'b0, 1'b0, 12);
        evts(0, 0);
        rd(TCC_OFS_REG_A);
        check("reverse phase capture", {31'h0, q >= 32'hC && q <= 32'hF}, 32'h1);
        wr(TCC_OFS_REG_A, 32'h00001234);
        src.drive(1'b1, 1'b1, 12);
        evts(1, 0);
        rd(TCC_OFS_REG_A);
        check("no capture on input b", q, 32'h00001234);
        setup(32'h7, 32'h20, 32'h8);
        repeat (20) @(posedge hclk);
        src.drive(1'b0, 1'b1, 100);
        src.drive(1'b0, 1'b0, 12);
        evts(0, 1);
        rd(TCC_OFS_REG_A);
        v = q;
        rd(TCC_OFS_REG_B);
        check("high width", q - v, 32'h00000064);
        setup(32'h4, 32'h08, 32'h4);
        src.drive(1'b0, 1'b1, 1);
        src.drive(1'b0, 1'b0, 12);
        evts(0, 0);
        src.drive(1'b0, 1'b1, 12);
        evts(0, 1);
        rd(TCC_OFS_REG_B);
        v = q;
        rd(TCC_OFS_COUNT);
        check("count kept", {31'h0, q > v && v >= 32'h10}, 32'h1);
        setup(32'h5, 32'h18, 32'hA);
        src.drive(1'b0, 1'b0, 12);
        evts(0, 1);
        check("pin on both capture", {31'h0, pin_o}, 32'h1);
        setup(32'h5, 32'h18, 32'h4);
        src.drive(1'b0, 1'b1, 12);
        evts(0, 1);
        check("pin held", {31'h0, pin_o}, 32'h0);
        wr(TCC_OFS_MODE, 32'h00000006);
        src.drive(1'b0, 1'b0, 12);
        check("pin edge toggle", {31'h0, pin_o}, 32'h1);
        src.drive(1'b1, 1'b0, 12);
        evts(1, 1);
        rd(TCC_OFS_REG_A);
        check("capture on input b", {31'h0, q >= 32'h18 && q <= 32'h20}, 32'h1);
        complete_run();
    end
endmodule : tcc_timer_tb

`default_nettype wire
